// >>> hw/wake_pkg.sv
package wake_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] LVL_ADDR = 8'h08;

  // control register fields
  localparam int EN_BIT = 0;
  localparam int CYC_BIT = 1;
  localparam int MOD_BIT = 2;
  localparam int PLO_BIT = 3;
  localparam int PHI_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status / level fields
  localparam int FLAG_BIT = 0;
  localparam int LVL_BIT = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int FILT_US = 16;
  localparam int FILT_CYC = FILT_US * CLK_MHZ;
  localparam int INT_US = 100;
  localparam int INT_CYC = INT_US * CLK_MHZ;
  localparam int INTD_US = 100;
  localparam int INTD_CYC = INTD_US * CLK_MHZ;
  localparam int CYC_PERIOD = 1000;
  localparam int CYC_ACTIVE = 500;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // device modes supplied by the mode controller
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_STOP = 4'b0010,
    MODE_SLEEP = 4'b0100,
    MODE_FAILSAFE = 4'b1000
  } dev_mode_e;

  // interrupt pulse generator states
  typedef enum logic [2:0] {
    INT_IDLE = 3'b001,
    INT_LOW = 3'b010,
    INT_GAP = 3'b100
  } int_state_e;

  typedef struct packed {
    logic pull_up;
    logic pull_dn;
  } pull_s;

endpackage : wake_pkg

// >>> hw/wake_input_monitor.sv
// Functional notes
// - both pin edges count as events
// - normal or stop mode raises interrupt
// - sleep mode wakes device
// - stop mode pin selects pfm or pwm
// - modulation selector bypasses filter delay
// - static sense monitors pin continuously
// - cyclic sense samples only during window
// - changes accepted after sixteen microseconds stable
// - software enables wake capability
// - live level readable in normal, stop
// - enable bit gates wake and interrupt
// - fail-safe transition requests restart mode
// - pin wake sets sticky source flag
// - pull select decode none, down, up, auto
// - auto mode follows detected pin level
// - interrupt low pulse one hundred microseconds
// - interrupt only when wake enabled
// - level status never causes interrupt
// - flags held until software clears
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module wake_input_monitor #(
  parameter int FILT_CYCLES = wake_pkg::FILT_CYC,
  parameter int INT_CYCLES = wake_pkg::INT_CYC,
  parameter int INTD_CYCLES = wake_pkg::INTD_CYC,
  parameter int CYC_PERIOD = wake_pkg::CYC_PERIOD,
  parameter int CYC_ACTIVE = wake_pkg::CYC_ACTIVE
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic wake_pin_in,
  input wire wake_pkg::dev_mode_e mode_in,
  output logic wake_request_out,
  output logic restart_request_out,
  output logic int_n_out,
  output logic buck_pwm_out,
  output wake_pkg::pull_s pull_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // control register and bus slave
  // ****************************************
  logic [31:0] ctrl_r;
  logic flag_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_ctrl;
  logic wr_stat_clr;
  logic event_qual;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ctrl = wr_go && (awaddr_r == wake_pkg::CTRL_ADDR);
  assign wr_stat_clr = wr_go && (awaddr_r == wake_pkg::STAT_ADDR) && wstrb_r[0] &&
    wdata_r[wake_pkg::FLAG_BIT];

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wake_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == wake_pkg::CTRL_ADDR || awaddr_r == wake_pkg::STAT_ADDR ||
            awaddr_r == wake_pkg::LVL_ADDR) begin
          s_axi_bresp <= wake_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= wake_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_r <= wake_pkg::CTRL_RST;
    end else if (wr_ctrl && wstrb_r[0]) begin
      ctrl_r[7:0] <= wdata_r[7:0];
    end
  end

  // sticky wake source flag, a new event beats a clear
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_r <= 1'b0;
    end else if (event_qual) begin
      flag_r <= 1'b1;
    end else if (wr_stat_clr) begin
      flag_r <= 1'b0;
    end
  end

  // ****************************************
  // pin synchroniser and filter
  // ****************************************
  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic [15:0] filt_cnt_r;
  logic [15:0] cyc_cnt_r;
  logic window;
  logic edge_evt;
  logic level_vis;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= wake_pin_in;
      sync2_r <= sync1_r;
    end
  end

  // cyclic sense: pin evaluated only in the first part of each period
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_cnt_r <= 16'h0000;
    end else if (cyc_cnt_r == 16'(CYC_PERIOD - 1)) begin
      cyc_cnt_r <= 16'h0000;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 16'h0001;
    end
  end
  assign window = !ctrl_r[wake_pkg::CYC_BIT] || (cyc_cnt_r < 16'(CYC_ACTIVE));

  // level must differ from accepted level for the whole filter time
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      filt_r <= 1'b0;
      filt_cnt_r <= 16'h0000;
    end else if (!window || sync2_r == filt_r) begin
      filt_cnt_r <= 16'h0000;
    end else if (filt_cnt_r == 16'(FILT_CYCLES - 1)) begin
      filt_r <= sync2_r;
      filt_cnt_r <= 16'h0000;
    end else begin
      filt_cnt_r <= filt_cnt_r + 16'h0001;
    end
  end

  assign edge_evt = window && (sync2_r != filt_r) && (filt_cnt_r == 16'(FILT_CYCLES - 1));
  assign event_qual = edge_evt && ctrl_r[wake_pkg::EN_BIT];

  // ****************************************
  // mode reaction
  // ****************************************
  logic int_fire;
  assign int_fire = event_qual && (mode_in == wake_pkg::MODE_NORMAL || mode_in == wake_pkg::MODE_STOP);

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_request_out <= 1'b0;
      restart_request_out <= 1'b0;
    end else begin
      wake_request_out <= event_qual && (mode_in == wake_pkg::MODE_SLEEP);
      restart_request_out <= event_qual && (mode_in == wake_pkg::MODE_FAILSAFE);
    end
  end

  // stop mode modulation selection uses synchronised level only
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buck_pwm_out <= 1'b0;
    end else if (ctrl_r[wake_pkg::MOD_BIT] && mode_in == wake_pkg::MODE_STOP) begin
      buck_pwm_out <= sync2_r;
    end else begin
      buck_pwm_out <= 1'b0;
    end
  end

  // pull current sources
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pull_out <= '0;
    end else begin
      case ({ctrl_r[wake_pkg::PHI_BIT], ctrl_r[wake_pkg::PLO_BIT]})
        2'b01: pull_out <= '{pull_up: 1'b0, pull_dn: 1'b1};
        2'b10: pull_out <= '{pull_up: 1'b1, pull_dn: 1'b0};
        2'b11: pull_out <= '{pull_up: sync2_r, pull_dn: !sync2_r};
        default: pull_out <= '0;
      endcase
    end
  end

  // ****************************************
  // interrupt pulse
  // ****************************************
  wake_pkg::int_state_e int_st_r;
  logic [15:0] int_cnt_r;
  logic int_pend_r;

  // level status feeds only the read path, never the interrupt
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_st_r <= wake_pkg::INT_IDLE;
      int_cnt_r <= 16'h0000;
      int_pend_r <= 1'b0;
    end else begin
      if (int_fire) begin
        int_pend_r <= 1'b1;
      end
      case (int_st_r)
        wake_pkg::INT_IDLE: begin
          if (int_fire || int_pend_r) begin
            int_st_r <= wake_pkg::INT_LOW;
            int_pend_r <= 1'b0;
            int_cnt_r <= 16'h0000;
          end
        end
        wake_pkg::INT_LOW: begin
          if (int_cnt_r == 16'(INT_CYCLES - 1)) begin
            int_st_r <= wake_pkg::INT_GAP;
            int_cnt_r <= 16'h0000;
          end else begin
            int_cnt_r <= int_cnt_r + 16'h0001;
          end
        end
        wake_pkg::INT_GAP: begin
          if (int_cnt_r == 16'(INTD_CYCLES - 1)) begin
            int_st_r <= wake_pkg::INT_IDLE;
            int_cnt_r <= 16'h0000;
          end else begin
            int_cnt_r <= int_cnt_r + 16'h0001;
          end
        end
        default: int_st_r <= wake_pkg::INT_IDLE;
      endcase
    end
  end
  assign int_n_out = (int_st_r != wake_pkg::INT_LOW);

  // ****************************************
  // read channel
  // ****************************************
  assign level_vis = sync2_r && (mode_in == wake_pkg::MODE_NORMAL || mode_in == wake_pkg::MODE_STOP);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= wake_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= wake_pkg::RESP_OKAY;
      if (s_axi_araddr == wake_pkg::CTRL_ADDR) begin
        s_axi_rdata <= {24'h000000, ctrl_r[7:0]};
      end else if (s_axi_araddr == wake_pkg::STAT_ADDR) begin
        s_axi_rdata <= {31'h00000000, flag_r};
      end else if (s_axi_araddr == wake_pkg::LVL_ADDR) begin
        s_axi_rdata <= {31'h00000000, level_vis};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= wake_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_int_start;
    int_fire && int_st_r == wake_pkg::INT_IDLE;
  endsequence

  AST_INT_ON_EVENT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    s_int_start |=> !int_n_out) else $error("interrupt not asserted after event");
  AST_INT_WIDTH: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $fell(int_n_out) |-> !int_n_out [*8]) else $error("interrupt pulse too short");
  AST_NO_INT_DISABLED: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !ctrl_r[wake_pkg::EN_BIT] && int_st_r == wake_pkg::INT_IDLE && !int_pend_r |=> int_n_out)
    else $error("interrupt while wake disabled");
  AST_SLEEP_WAKE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    event_qual && mode_in == wake_pkg::MODE_SLEEP |=> wake_request_out) else $error("no wake from sleep");
  AST_RESTART: assert property (@(posedge clock_in) disable iff (!nrst_in)
    event_qual && mode_in == wake_pkg::MODE_FAILSAFE |=> restart_request_out) else $error("no restart");
  AST_FLAG_SET: assert property (@(posedge clock_in) disable iff (!nrst_in)
    event_qual |=> flag_r) else $error("wake flag not set");
  AST_FLAG_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
    flag_r && !wr_stat_clr |=> flag_r) else $error("wake flag lost");
  AST_FILTER: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $changed(filt_r) |-> $past(sync2_r) == filt_r) else $error("filter took unstable level");
  AST_MODSEL: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_r[wake_pkg::MOD_BIT] && mode_in == wake_pkg::MODE_STOP |=> buck_pwm_out == $past(sync2_r))
    else $error("modulation select wrong");
  AST_AUTO_PULL: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_r[wake_pkg::PHI_BIT] && ctrl_r[wake_pkg::PLO_BIT] |=> pull_out.pull_up == $past(sync2_r))
    else $error("auto pull wrong");

endmodule : wake_input_monitor

// >>> verif/wake_switch_model.sv
`timescale 1ns/1ps
// external switch on the wake pin, always driven
module wake_switch_model (
  input wire logic clock_in,
  output logic pin_out
);
  initial pin_out = 1'b0;

  task automatic flip();
    @(posedge clock_in);
    pin_out <= ~pin_out;
  endtask : flip

  // pulse of n cycles that must be rejected, by the filter or by the cyclic sense window
  task automatic glitch(input int n);
    flip();
    repeat (n) @(posedge clock_in);
    pin_out <= ~pin_out;
  endtask : glitch
endmodule : wake_switch_model

// >>> verif/wake_input_monitor_test.sv
`timescale 1ns/1ps
module wake_input_monitor_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pin;
  wake_pkg::dev_mode_e mode = wake_pkg::MODE_NORMAL;
  logic wake, rst_req, int_n, pwm;
  wake_pkg::pull_s pull;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  int mismatches = 0, tests_run = 0, lo, wk, rs;
  int cyc = 0;

  wake_switch_model sw (.clock_in(clk), .pin_out(pin));
  wake_input_monitor #(.FILT_CYCLES(4), .INT_CYCLES(10), .INTD_CYCLES(4), .CYC_PERIOD(20), .CYC_ACTIVE(10)) uut (
    .clock_in(clk), .nrst_in(nrst), .wake_pin_in(pin), .mode_in(mode),
    .wake_request_out(wake), .restart_request_out(rst_req), .int_n_out(int_n),
    .buck_pwm_out(pwm), .pull_out(pull),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial forever #20 clk = ~clk;

  // follows the cyclic sense counter, so window tests know the phase
  always @(posedge clk) begin
    if (nrst) cyc <= cyc + 1;
  end

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'h1);
    logic ah, wh, b;
    @(posedge clk);
    awaddr <= a; wdata <= v; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ah = 1'b0; wh = 1'b0;
    do begin
      @(negedge clk);
      ah = ah | (awvalid & awready);
      wh = wh | (wvalid & wready);
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!(ah && wh));
    do begin
      @(negedge clk);
      b = bvalid;
      r = bresp;
      @(posedge clk);
    end while (b !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ah, b;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arready;
      @(posedge clk);
    end while (ah !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (b !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // count interrupt-low cycles and request pulses over a span
  task automatic watch(input int n);
    lo = 0; wk = 0; rs = 0;
    repeat (n) begin
      @(negedge clk);
      lo += (int_n === 1'b0);
      wk += (wake === 1'b1);
      rs += (rst_req === 1'b1);
    end
    @(posedge clk);
  endtask : watch

  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(wake_pkg::CTRL_ADDR); chk(d, 32'h0);
    rd(8'h0c); chk(32'(r), 32'(wake_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h1); chk(32'(r), 32'(wake_pkg::RESP_SLVERR));
    wr(wake_pkg::CTRL_ADDR, 32'h1); chk(32'(r), 32'(wake_pkg::RESP_OKAY));
    wr(wake_pkg::CTRL_ADDR, 32'h1e, 4'he);
    rd(wake_pkg::CTRL_ADDR); chk(d, 32'h1);
    sw.flip(); watch(40); chk(lo, 10);
    chk(wk, 0);
    rd(wake_pkg::LVL_ADDR); chk(d, 32'h1);
    rd(wake_pkg::STAT_ADDR); chk(d, 32'h1);
    rd(wake_pkg::STAT_ADDR); chk(d, 32'h1);
    wr(wake_pkg::STAT_ADDR, 32'h1);
    rd(wake_pkg::STAT_ADDR); chk(d, 32'h0);
    sw.glitch(2); watch(40); chk(lo, 0);
    sw.flip(); watch(40); chk(lo, 10);
    mode <= wake_pkg::MODE_SLEEP;
    sw.flip(); watch(40); chk(wk, 1);
    chk(lo, 0);
    rd(wake_pkg::LVL_ADDR); chk(d, 32'h0);
    mode <= wake_pkg::MODE_FAILSAFE;
    sw.flip(); watch(40); chk(rs, 1);
    mode <= wake_pkg::MODE_NORMAL;
    wr(wake_pkg::CTRL_ADDR, 32'h0);
    sw.flip(); watch(40); chk(lo, 0);
    wr(wake_pkg::CTRL_ADDR, 32'h3);
    // window period 20, active 10: a 10-cycle pulse then falls wholly outside it
    do @(negedge clk); while (cyc % 20 != 7);
    sw.glitch(10); watch(40); chk(lo, 0);
    sw.flip(); watch(40); chk(lo, 10);
    sw.flip(); watch(40); chk(lo, 10);
    for (int i = 0; i < 4; i++) begin
      wr(wake_pkg::CTRL_ADDR, 32'(i) << wake_pkg::PLO_BIT);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(pull), (i == 3) ? 32'h2 : 32'(i));
    end
    sw.flip(); watch(20); chk(32'(pull), 32'h1);
    wr(wake_pkg::CTRL_ADDR, 32'h5);
    mode <= wake_pkg::MODE_STOP;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pwm, 1'b0);
    sw.flip();
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pwm, 1'b1);
    watch(40); chk(lo, 10);
    rd(wake_pkg::LVL_ADDR); chk(d, 32'h1);
    end_sim();
  end
endmodule : wake_input_monitor_test
